// ===== design/crf_pkg.sv
// Shared constants and types of the core register set.
// Assumes a 20 MHz pclk and an APB master with 32-bit data.
package crf_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets on APB)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ACC = 8'h00;
  localparam logic [7:0] OFS_INDEX = 8'h04;
  localparam logic [7:0] OFS_STACK = 8'h08;
  localparam logic [7:0] OFS_PROG = 8'h0C;
  localparam logic [7:0] OFS_CODES = 8'h10;
  localparam logic [7:0] OFS_CMD = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_CONTROL = 8'h1C;
  localparam logic [7:0] OFS_MEM_ADDR = 8'h20;
  localparam logic [7:0] OFS_MEM_DATA = 8'h24;

  // ----------------------------------------------------------------
  // Reset values and vectors
  // ----------------------------------------------------------------
  localparam logic [15:0] STACK_RST = 16'h00FF;
  localparam logic [7:0] STACK_LOW_RELOAD = 8'hFF;
  localparam logic [15:0] RESET_VEC = 16'hFFFE;
  localparam logic [15:0] TRAP_VEC = 16'hFFFC;
  localparam logic [15:0] MON_TRAP_VEC = 16'hFEFC;
  localparam logic [15:0] IRQ_VEC_TOP = 16'hFFFA;
  localparam logic [7:0] CODES_ONES = 8'h60;
  localparam logic [7:0] CODES_RST = 8'h68;

  // ----------------------------------------------------------------
  // Condition code field positions
  // ----------------------------------------------------------------
  localparam int unsigned CC_V = 7;
  localparam int unsigned CC_H = 4;
  localparam int unsigned CC_I = 3;
  localparam int unsigned CC_N = 2;
  localparam int unsigned CC_Z = 1;
  localparam int unsigned CC_C = 0;

  // Control and status bits
  localparam int unsigned CTL_BRK_EN = 0;
  localparam int unsigned CTL_MONITOR = 1;
  localparam int unsigned TRAP_BYTES = 5;

  // ----------------------------------------------------------------
  // Operations accepted through the command register
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADD_CARRY = 5'h02, OP_SUB = 5'h03,
    OP_SUB_BORROW = 5'h04, OP_AND = 5'h05, OP_OR = 5'h06, OP_XOR = 5'h07,
    OP_LOAD = 5'h08, OP_SHIFT_LEFT = 5'h09, OP_ROTATE_RIGHT = 5'h0A,
    OP_DECIMAL_ADJUST = 5'h0B, OP_CLEAR_MASK = 5'h0C, OP_SET_MASK = 5'h0D,
    OP_STACK_LOW_BYTE_RELOAD = 5'h0E, OP_PUSH_ACC = 5'h0F, OP_PULL_ACC = 5'h10,
    OP_PUSH_INDEX_UPPER = 5'h11, OP_PULL_INDEX_UPPER = 5'h12,
    OP_SOFTWARE_TRAP = 5'h13, OP_RETURN_FROM_TRAP = 5'h14,
    OP_JUMP_INDEXED = 5'h15, OP_SIGNED_LESS_BRANCH = 5'h16
  } crf_op_e;

  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_RVEC_HI = 7'h01, ST_RVEC_LO = 7'h02, ST_IDLE = 7'h04, ST_PUSH = 7'h08,
    ST_VEC_HI = 7'h10, ST_VEC_LO = 7'h20, ST_PULL = 7'h40
  } crf_state_e;

endpackage : crf_pkg

// ===== design/crf_mem_if.sv
// Byte port between the register core and its local memory.
// Assumes one master (the core) and an asynchronous-read memory.
`timescale 1ns/10ps
`default_nettype none
interface crf_mem_if;
  logic [15:0] addr;
  logic we;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport core (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface : crf_mem_if
`default_nettype wire

// ===== design/crf_mem.sv
// Local byte memory holding the stack page and vector page.
// Assumes writes only while ce is high; reads are combinational.
`timescale 1ns/10ps
`default_nettype none
module crf_mem (
  // Clock
  input wire logic pclk,
  input wire logic ce,
  // Core port
  crf_mem_if.mem bus
);
  import crf_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Index keeps page 0, page $FE and page $FF apart with few bits
  logic [9:0] index;
  logic [7:0] bytes_q [1024];

  // Address fold
  assign index = {bus.addr[15], bus.addr[8], bus.addr[7:0]};
  assign bus.rdata = bytes_q[index];

  // Write port, frozen with the clock enable
  always_ff @(posedge pclk) begin
    if (ce && bus.we) begin
      bytes_q[index] <= bus.wdata;
    end
  end
endmodule : crf_mem
`default_nettype wire

// ===== design/crf_alu.sv
// Eight-bit arithmetic unit and its flag results.
// Assumes the caller decides which flags to keep per operation.
`timescale 1ns/10ps
`default_nettype none
module crf_alu (
  // Operation
  input wire crf_pkg::crf_op_e op,
  input wire logic [7:0] a,
  input wire logic [7:0] m,
  input wire logic [7:0] flags_in,
  // Results
  output logic [7:0] res,
  output logic [7:0] flags_out
);
  import crf_pkg::*;

  logic [8:0] wide;
  logic [4:0] nib;
  logic cy;
  logic [7:0] corr;

  // Result and flags
  always_comb begin
    flags_out = flags_in;
    cy = flags_in[CC_C] & (op == OP_ADD_CARRY || op == OP_SUB_BORROW);
    nib = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cy};
    wide = {1'b0, a} + {1'b0, m} + {8'h00, cy};
    corr = 8'h00;
    res = a;
    unique case (op)
      OP_ADD, OP_ADD_CARRY: begin
        res = wide[7:0];
        flags_out[CC_C] = wide[8];
        // carry from bit 3 into 4
        flags_out[CC_H] = nib[4];
        flags_out[CC_V] = (a[7] & m[7] & ~res[7]) | (~a[7] & ~m[7] & res[7]);
      end
      OP_SUB, OP_SUB_BORROW: begin
        wide = {1'b0, a} - {1'b0, m} - {8'h00, cy};
        res = wide[7:0];
        flags_out[CC_C] = wide[8];
        flags_out[CC_V] = (a[7] & ~m[7] & ~res[7]) | (~a[7] & m[7] & res[7]);
      end
      OP_AND, OP_OR, OP_XOR, OP_LOAD: begin
        res = (op == OP_AND) ? (a & m) : (op == OP_OR) ? (a | m) :
              (op == OP_XOR) ? (a ^ m) : m;
        flags_out[CC_V] = 1'b0;
      end
      OP_SHIFT_LEFT, OP_ROTATE_RIGHT: begin
        res = (op == OP_SHIFT_LEFT) ? {a[6:0], 1'b0} : {flags_in[CC_C], a[7:1]};
        flags_out[CC_C] = (op == OP_SHIFT_LEFT) ? a[7] : a[0];
        flags_out[CC_V] = res[7] ^ flags_out[CC_C];
      end
      OP_DECIMAL_ADJUST: begin
        if (flags_in[CC_C] || a > 8'h99) begin
          corr[7:4] = 4'h6;
          flags_out[CC_C] = 1'b1;
        end
        if (flags_in[CC_H] || a[3:0] > 4'h9) begin
          corr[3:0] = 4'h6;
        end
        res = a + corr;
      end
      default: res = a;
    endcase
    flags_out[CC_N] = res[7];
    flags_out[CC_Z] = (res == 8'h00);
  end
endmodule : crf_alu
`default_nettype wire

// ===== design/crf_core.sv
// Programmer-visible register set with its stack, trap and flag logic.
// Assumes an APB master, level interrupt lines and a break request pin,
// all synchronous to pclk.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
module crf_core #(
  parameter int unsigned IRQ_N = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Requests from peripherals and break logic
  input wire logic [IRQ_N-1:0] irq_lines,
  input wire logic break_req,
  // Core state
  output logic break_active
);
  import crf_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  crf_state_e state_q, state_d;
  crf_op_e cmd_op_q, cmd_op_d;
  logic [7:0] acc_q, acc_d, cmd_arg_q, cmd_arg_d;
  logic [15:0] index_q, index_d, stack_pointer_q, stack_pointer_d;
  logic [15:0] program_counter_q, program_counter_d, vec_q, vec_d;
  logic [15:0] maddr_q, maddr_d;
  logic [7:0] condition_codes_q, condition_codes_d;
  logic [2:0] step_q, step_d;
  logic cmd_pend_q, cmd_pend_d, brk_act_q, brk_act_d, ok_q, ok_d;
  logic [1:0] ctl_q, ctl_d;
  logic [31:0] rdata_q, rdata_d;

  // Bus decode
  logic core_sel, wr_en, mapped, take_irq;
  logic [31:0] rd_mux, bmask;
  logic [7:0] codes_view, alu_res, alu_flags, push_byte;
  logic [15:0] irq_vec;

  crf_mem_if mbus ();

  crf_mem u_mem (
    .pclk(pclk),
    .ce(ce),
    .bus(mbus)
  );

  crf_alu u_alu (
    .op(cmd_op_q),
    .a(acc_q),
    .m(cmd_arg_q),
    .flags_in(condition_codes_q),
    .res(alu_res),
    .flags_out(alu_flags)
  );

  // ----------------------------------------------------------------
  // APB decode and read mux
  // ----------------------------------------------------------------
  // fixed ones in codes
  assign codes_view = condition_codes_q | CODES_ONES;
  assign core_sel = psel && (paddr <= OFS_CMD || paddr == OFS_MEM_DATA);
  assign mapped = paddr <= OFS_MEM_DATA && paddr[1:0] == 2'b00;
  // Held low while frozen, so no transfer completes without its write
  assign pready = penable && ok_q && ce;
  assign pslverr = pready && !mapped;
  assign wr_en = psel && pready && pwrite && mapped;
  assign prdata = rdata_q;
  assign break_active = brk_act_q;
  assign bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // Read data, captured a cycle ahead of the access phase
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFS_ACC: rd_mux = {24'h00_0000, acc_q};
      OFS_INDEX: rd_mux = {16'h0000, index_q};
      OFS_STACK: rd_mux = {16'h0000, stack_pointer_q};
      OFS_PROG: rd_mux = {16'h0000, program_counter_q};
      OFS_CODES: rd_mux = {24'h00_0000, codes_view};
      OFS_CMD: rd_mux = {16'h0000, cmd_arg_q, 3'b000, cmd_op_q};
      OFS_STATUS: rd_mux = {28'h000_0000, !condition_codes_q[CC_I] ? 1'b0 : 1'b1,
                            brk_act_q, cmd_pend_q, state_q != ST_IDLE};
      OFS_CONTROL: rd_mux = {30'h0000_0000, ctl_q};
      OFS_MEM_ADDR: rd_mux = {16'h0000, maddr_q};
      OFS_MEM_DATA: rd_mux = {24'h00_0000, mbus.rdata};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Interrupt priority
  // ----------------------------------------------------------------
  // lowest line number wins
  always_comb begin
    irq_vec = IRQ_VEC_TOP;
    for (int k = IRQ_N - 1; k >= 0; k--) begin
      if (irq_lines[k]) begin
        irq_vec = IRQ_VEC_TOP - 16'(2 * k);
      end
    end
  end
  assign take_irq = !condition_codes_q[CC_I] && (|irq_lines);

  // Byte saved at each trap step; the index upper byte is left out
  // no index upper byte
  always_comb begin
    unique case (step_q)
      3'd0: push_byte = program_counter_q[7:0];
      3'd1: push_byte = program_counter_q[15:8];
      3'd2: push_byte = index_q[7:0];
      3'd3: push_byte = acc_q;
      default: push_byte = codes_view;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state of the register set
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    acc_d = acc_q;
    index_d = index_q;
    stack_pointer_d = stack_pointer_q;
    program_counter_d = program_counter_q;
    condition_codes_d = condition_codes_q;
    vec_d = vec_q;
    step_d = step_q;
    cmd_op_d = cmd_op_q;
    cmd_arg_d = cmd_arg_q;
    cmd_pend_d = cmd_pend_q;
    brk_act_d = brk_act_q;
    ctl_d = ctl_q;
    maddr_d = maddr_q;
    mbus.addr = maddr_q;
    mbus.we = 1'b0;
    mbus.wdata = pwdata[7:0];
    // Bus waits on core_sel registers while the sequencer owns the core
    ok_d = psel && !(penable && pready) && !(core_sel && state_q != ST_IDLE);
    rdata_d = psel ? rd_mux : rdata_q;
    unique case (state_q)
      ST_RVEC_HI: begin
        mbus.addr = RESET_VEC;
        program_counter_d[15:8] = mbus.rdata;
        state_d = ST_RVEC_LO;
      end
      ST_RVEC_LO: begin
        mbus.addr = RESET_VEC + 16'h0001;
        program_counter_d[7:0] = mbus.rdata;
        state_d = ST_IDLE;
      end
      ST_PUSH: begin
        mbus.addr = stack_pointer_q;
        mbus.we = 1'b1;
        mbus.wdata = push_byte;
        stack_pointer_d = stack_pointer_q - 16'h0001;
        step_d = step_q + 3'd1;
        if (step_q == 3'(TRAP_BYTES - 1)) begin
          condition_codes_d[CC_I] = 1'b1;
          state_d = ST_VEC_HI;
        end
      end
      ST_VEC_HI: begin
        mbus.addr = vec_q;
        program_counter_d[15:8] = mbus.rdata;
        state_d = ST_VEC_LO;
      end
      ST_VEC_LO: begin
        mbus.addr = vec_q + 16'h0001;
        program_counter_d[7:0] = mbus.rdata;
        state_d = ST_IDLE;
      end
      ST_PULL: begin
        mbus.addr = stack_pointer_q + 16'h0001;
        stack_pointer_d = stack_pointer_q + 16'h0001;
        step_d = step_q + 3'd1;
        unique case (step_q)
          3'd0: condition_codes_d = mbus.rdata & ~CODES_ONES;
          3'd1: acc_d = mbus.rdata;
          3'd2: index_d[7:0] = mbus.rdata;
          3'd3: program_counter_d[15:8] = mbus.rdata;
          default: begin
            program_counter_d[7:0] = mbus.rdata;
            state_d = ST_IDLE;
            if (!break_req) begin
              brk_act_d = 1'b0;
            end
          end
        endcase
      end
      ST_IDLE: begin
        if (!core_sel) begin
          step_d = 3'd0;
          if (ctl_q[CTL_BRK_EN] && break_req && !brk_act_q) begin
            brk_act_d = 1'b1;
            vec_d = ctl_q[CTL_MONITOR] ? MON_TRAP_VEC : TRAP_VEC;
            state_d = ST_PUSH;
          end else if (take_irq) begin
            vec_d = irq_vec;
            state_d = ST_PUSH;
          end else if (cmd_pend_q) begin
            cmd_pend_d = 1'b0;
            program_counter_d = program_counter_q + 16'h0001;
            unique case (cmd_op_q)
              OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_BORROW, OP_AND, OP_OR, OP_XOR,
              OP_LOAD: begin
                acc_d = alu_res;
                condition_codes_d = alu_flags;
                program_counter_d = program_counter_q + 16'h0002;
              end
              OP_SHIFT_LEFT, OP_ROTATE_RIGHT, OP_DECIMAL_ADJUST: begin
                acc_d = alu_res;
                condition_codes_d = alu_flags;
              end
              OP_CLEAR_MASK: condition_codes_d[CC_I] = 1'b0;
              OP_SET_MASK: condition_codes_d[CC_I] = 1'b1;
              OP_STACK_LOW_BYTE_RELOAD: stack_pointer_d[7:0] = STACK_LOW_RELOAD;
              OP_PUSH_ACC, OP_PUSH_INDEX_UPPER: begin
                mbus.addr = stack_pointer_q;
                mbus.we = 1'b1;
                mbus.wdata = (cmd_op_q == OP_PUSH_ACC) ? acc_q : index_q[15:8];
                stack_pointer_d = stack_pointer_q - 16'h0001;
              end
              OP_PULL_ACC, OP_PULL_INDEX_UPPER: begin
                mbus.addr = stack_pointer_q + 16'h0001;
                stack_pointer_d = stack_pointer_q + 16'h0001;
                if (cmd_op_q == OP_PULL_ACC) begin
                  acc_d = mbus.rdata;
                end else begin
                  index_d[15:8] = mbus.rdata;
                end
              end
              OP_SOFTWARE_TRAP: begin
                vec_d = ctl_q[CTL_MONITOR] ? MON_TRAP_VEC : TRAP_VEC;
                state_d = ST_PUSH;
              end
              OP_RETURN_FROM_TRAP: state_d = ST_PULL;
              OP_JUMP_INDEXED: program_counter_d = index_q;
              OP_SIGNED_LESS_BRANCH: begin
                program_counter_d = program_counter_q + 16'h0002;
                if (condition_codes_q[CC_N] ^ condition_codes_q[CC_V]) begin
                  program_counter_d = program_counter_q + 16'h0002 +
                                      {{8{cmd_arg_q[7]}}, cmd_arg_q};
                end
              end
              default: program_counter_d = program_counter_q + 16'h0001;
            endcase
          end
        end
        // Software access, only while the sequencer rests
        if (wr_en) begin
          unique case (paddr)
            OFS_ACC: acc_d = pstrb[0] ? pwdata[7:0] : acc_q;
            OFS_INDEX: index_d = (index_q & ~bmask[15:0]) | (pwdata[15:0] & bmask[15:0]);
            OFS_STACK: begin
              stack_pointer_d = (stack_pointer_q & ~bmask[15:0]) |
                                (pwdata[15:0] & bmask[15:0]);
            end
            OFS_PROG: begin
              program_counter_d = (program_counter_q & ~bmask[15:0]) |
                                  (pwdata[15:0] & bmask[15:0]);
            end
            OFS_CODES: if (pstrb[0]) begin
              condition_codes_d = (pwdata[7:0] & ~CODES_ONES) |
                                  (condition_codes_q & (8'h01 << CC_I));
            end
            OFS_CMD: begin
              cmd_op_d = crf_op_e'(pwdata[4:0]);
              cmd_arg_d = pwdata[15:8];
              cmd_pend_d = 1'b1;
            end
            OFS_MEM_DATA: mbus.we = pstrb[0];
            default: cmd_pend_d = cmd_pend_q;
          endcase
        end
      end
      default: state_d = ST_RVEC_HI;
    endcase
    // Registers reachable while the sequencer runs
    if (wr_en && paddr == OFS_CONTROL && pstrb[0]) begin
      ctl_d = pwdata[1:0];
    end
    if (wr_en && paddr == OFS_MEM_ADDR) begin
      maddr_d = (maddr_q & ~bmask[15:0]) | (pwdata[15:0] & bmask[15:0]);
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_RVEC_HI;
      acc_q <= 8'h00;
      index_q <= 16'h0000;
      stack_pointer_q <= STACK_RST;
      program_counter_q <= 16'h0000;
      condition_codes_q <= CODES_RST & ~CODES_ONES;
      vec_q <= 16'h0000;
      step_q <= 3'd0;
      cmd_op_q <= OP_NOP;
      cmd_arg_q <= 8'h00;
      cmd_pend_q <= 1'b0;
      brk_act_q <= 1'b0;
      ctl_q <= 2'b00;
      maddr_q <= 16'h0000;
      ok_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      state_q <= state_d;
      acc_q <= acc_d;
      index_q <= index_d;
      stack_pointer_q <= stack_pointer_d;
      program_counter_q <= program_counter_d;
      condition_codes_q <= condition_codes_d;
      vec_q <= vec_d;
      step_q <= step_d;
      cmd_op_q <= cmd_op_d;
      cmd_arg_q <= cmd_arg_d;
      cmd_pend_q <= cmd_pend_d;
      brk_act_q <= brk_act_d;
      ctl_q <= ctl_d;
      maddr_q <= maddr_d;
      ok_q <= ok_d;
      rdata_q <= rdata_d;
    end
  end
endmodule : crf_core
`default_nettype wire

// ===== verification/crf_core_assertions.sv
// Checker for the APB port and break status of crf_core.
// Assumes binding onto crf_core, single pclk domain.
`timescale 1ns/10ps
`default_nettype none
module crf_core_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Break
  input wire logic break_req,
  input wire logic break_active
);
  import crf_pkg::*;
  logic xfer;
  logic unmapped;
  // Completed transfer and address decode
  assign xfer = psel && penable && pready;
  assign unmapped = paddr > OFS_MEM_DATA || paddr[1:0] != 2'b00;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_needs_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  chk_err_unmapped: assert property (xfer && unmapped |-> pslverr)
    else $error("no error on unmapped");
  chk_no_err_mapped: assert property (xfer && !unmapped |-> !pslverr)
    else $error("error on mapped");
  chk_bad_read_zero: assert property (xfer && unmapped && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_codes_ones: assert property (xfer && !pwrite && paddr == OFS_CODES |->
    prdata[6:5] == 2'b11)
    else $error("codes bits 6,5 not one");
  chk_status_no_wait: assert property (psel && penable && ce && paddr == OFS_STATUS |-> pready)
    else $error("status read stalled");
  chk_ready_one_cycle: assert property (xfer |=> !pready)
    else $error("pready held two cycles");
  chk_break_cause: assert property ($rose(break_active) |-> $past(break_req))
    else $error("break without request");
  cover property (xfer && unmapped);
  cover property ($rose(break_active));
  cover property ($fell(break_active));
endmodule : crf_core_chk
bind crf_core crf_core_chk crf_core_chk_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .break_req(break_req), .break_active(break_active));
`default_nettype wire

// ===== verification/crf_periph.sv
// Model of the break source and peripheral request lines.
// Assumes the bench commands the break level and the request lines.
`timescale 1ns/10ps
`default_nettype none
module crf_periph (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control
  input wire logic brk_set,
  input wire logic [3:0] irq_set,
  // Requests to the core
  output logic [3:0] irq_lines,
  output logic break_req
);
  // Break and request levels held until the bench withdraws them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_req <= 1'b0;
      irq_lines <= 4'h0;
    end else begin
      break_req <= brk_set;
      irq_lines <= irq_set;
    end
  end
endmodule : crf_periph
`default_nettype wire

// ===== verification/test_cpu_core_registers_and_flags.sv
// Self-checking bench for crf_core over APB.
// Assumes crf_periph as break source and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module test_cpu_core_registers_and_flags;
  import crf_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, brk_set = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, a, m, r, sp, v;
  logic pready, pslverr, break_active, break_req, err;
  logic [3:0] irq_lines, irq_set = 4'h0;
  logic [7:0] stk[$];
  int err_total = 0, cmp_count = 0;
  initial forever #25 pclk = ~pclk;
  crf_periph crf_periph_inst (.pclk(pclk), .presetn(presetn), .brk_set(brk_set),
    .irq_set(irq_set), .irq_lines(irq_lines), .break_req(break_req));
  crf_core crf_core_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_lines(irq_lines),
    .break_req(break_req), .break_active(break_active));
  // One APB transfer; data and error taken at the edge that sees pready
  // The idle cycle after it lets a written command run
  task automatic bus(input int w, input logic [7:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= (w != 0);
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : bus
  // One byte into the local memory through the window
  task automatic poke(input logic [15:0] ad, input logic [7:0] b);
    bus(1, OFS_MEM_ADDR, {16'h0000, ad});
    bus(1, OFS_MEM_DATA, {24'h00_0000, b});
  endtask : poke
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic close_out;
    if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  // Watchdog; the run needs well under a thousand cycles
  initial begin
    #200000;
    err_total++;
    close_out();
  end
  initial begin
    a = $urandom(35);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    bus(0, OFS_STACK, 0);
    chk("stack", 32'h0000_00FF, rd);
    chk("slverr", 0, 32'(err));
    bus(0, OFS_CODES, 0);
    chk("codes", 32'h0000_0068, rd);
    // Add loop; first pass sums to zero.
    for (int k = 0; k < 6; k++) begin
      a = $urandom % 256;
      m = (k == 0) ? (256 - a) % 256 : $urandom % 256;
      r = a + m;
      bus(1, OFS_ACC, a);
      bus(1, OFS_CMD, {16'h0, m[7:0], 3'b000, OP_ADD});
      bus(0, OFS_ACC, 0);
      chk("acc", r % 256, rd);
      bus(0, OFS_CODES, 0);
      chk("codes", {24'h0, (r[7] ^ a[7]) & ~(a[7] ^ m[7]), 2'b11, (a % 16 + m % 16) > 15,
        1'b1, r[7], r[7:0] == 8'h00, r[8]}, rd);
    end
    // Mask survives a write of zero; only the clear op or a return from trap removes it
    bus(1, OFS_CODES, 0);
    bus(0, OFS_CODES, 0);
    chk("mask", 1, 32'(rd[3]));
    bus(1, OFS_CMD, {27'h0, OP_CLEAR_MASK});
    bus(0, OFS_CODES, 0);
    chk("mask", 0, 32'(rd[3]));
    // Low byte reload, then push and pull
    sp = $urandom % 65536;
    bus(1, OFS_STACK, sp);
    bus(1, OFS_CMD, {27'h0, OP_STACK_LOW_BYTE_RELOAD});
    sp = sp | 255;
    bus(0, OFS_STACK, 0);
    chk("stack", sp, rd);
    stk.push_back(r[7:0]);
    bus(1, OFS_CMD, {27'h0, OP_PUSH_ACC});
    bus(0, OFS_STACK, 0);
    chk("stack", sp - 1, rd);
    bus(1, OFS_ACC, ~r);
    bus(1, OFS_CMD, {27'h0, OP_PULL_ACC});
    bus(0, OFS_STACK, 0);
    chk("stack", sp, rd);
    bus(0, OFS_ACC, 0);
    chk("pulled", {24'h0, stk.pop_back()}, rd);
    // Break trap stacks five bytes and masks; return unwinds it
    bus(1, OFS_CONTROL, 1);
    brk_set <= 1'b1;
    wait (break_active === 1'b1);
    @(posedge pclk);
    brk_set <= 1'b0;
    bus(0, OFS_STACK, 0);
    chk("stack", sp - 5, rd);
    bus(0, OFS_CODES, 0);
    chk("mask", 1, 32'(rd[3]));
    bus(1, OFS_CMD, {27'h0, OP_RETURN_FROM_TRAP});
    bus(0, OFS_CODES, 0);
    chk("mask", 0, 32'(rd[3]));
    bus(0, OFS_STACK, 0);
    chk("stack", sp, rd);
    chk("break", 0, 32'(break_active));
    // Masked lines wait; unmasked, line 1 beats line 2 and loads its vector
    v = $urandom % 65536;
    poke(16'hFFF8, v[15:8]);
    poke(16'hFFF9, v[7:0]);
    bus(1, OFS_CMD, {27'h0, OP_SET_MASK});
    irq_set <= 4'h6;
    repeat (4) @(posedge pclk);
    bus(0, OFS_STACK, 0);
    chk("stack", sp, rd);
    bus(1, OFS_CMD, {27'h0, OP_CLEAR_MASK});
    @(posedge pclk);
    bus(0, OFS_PROG, 0);
    chk("prog", v, rd);
    irq_set <= 4'h0;
    bus(0, OFS_STACK, 0);
    chk("stack", sp - 5, rd);
    bus(1, OFS_CMD, {27'h0, OP_RETURN_FROM_TRAP});
    // Software trap in monitor mode; stack kept clear of the vector bytes
    v = $urandom % 65536;
    bus(1, OFS_STACK, {16'h0000, STACK_RST});
    poke(MON_TRAP_VEC, v[15:8]);
    poke(MON_TRAP_VEC + 16'h0001, v[7:0]);
    bus(1, OFS_CONTROL, 2);
    bus(1, OFS_CMD, {27'h0, OP_SOFTWARE_TRAP});
    bus(0, OFS_PROG, 0);
    chk("prog", v, rd);
    bus(1, OFS_CMD, {27'h0, OP_RETURN_FROM_TRAP});
    bus(0, 8'h28, 0);
    chk("slverr", 1, 32'(err));
    chk("bad read", 0, rd);
    close_out();
  end
endmodule : test_cpu_core_registers_and_flags
`default_nettype wire
